//--- common/onewire_bridge_map.vh
// Register layout, command codes and timing constants of the bridge configuration/status block
`ifndef ONEWIRE_BRIDGE_MAP_VH
`define ONEWIRE_BRIDGE_MAP_VH

// Function command codes seen by this block
`define CMD_DEVICE_RESET 8'hf0
`define CMD_SET_POINTER 8'he1
`define CMD_WRITE_CONFIG 8'hd2

// Read pointer select codes
`define PTR_STATUS 8'hf0
`define PTR_READ_DATA 8'he1
`define PTR_CONFIG 8'hc3

// Configuration bit positions
`define CFG_ACTIVE_PULLUP 0
`define CFG_ZERO_BIT 1
`define CFG_STRONG_PULLUP 2
`define CFG_BUS_SPEED 3
`define CFG_RESET_VALUE 8'h00

// Status bit positions
`define STS_BUSY 0
`define STS_PRESENCE 1
`define STS_SHORT 2
`define STS_LINE_LEVEL 3
`define STS_RESET 4
`define STS_SINGLE_BIT 5
`define STS_TRIPLET_SECOND 6
`define STS_DIRECTION 7

// Timing
`define CLOCK_MHZ 100
`define ACTIVE_PULLUP_ON_TIME_NS 2000
`define ACTIVE_PULLUP_ON_CYCLES \
	((`ACTIVE_PULLUP_ON_TIME_NS * `CLOCK_MHZ / 1000) < 1 ? 1 : \
	(`ACTIVE_PULLUP_ON_TIME_NS * `CLOCK_MHZ / 1000))

`endif

//--- src/line_sampler.v
// Two-stage synchroniser and edge finder for the bus line input
`timescale 1ns/1ps
module line_sampler (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Raw pin
	input wire line_i,
	// Synchronised view
	output wire level_o,
	output wire rise_o,
	output wire fall_o
);

reg meta_reg;
reg sync_reg;
reg prev_reg;

// Idle bus is high, so reset to 1 avoids a false edge
always @(posedge clock_i) begin
	if (rst_i) begin
		meta_reg <= 1'b1;
		sync_reg <= 1'b1;
		prev_reg <= 1'b1;
	end else begin
		meta_reg <= line_i;
		sync_reg <= meta_reg;
		prev_reg <= sync_reg;
	end
end

assign level_o = sync_reg;
assign rise_o = sync_reg & ~prev_reg;
assign fall_o = ~sync_reg & prev_reg;

endmodule

//--- src/onewire_bridge_config_status.v
// Configuration and status register logic of the bridge, with pullup control
`timescale 1ns/1ps
`include "onewire_bridge_map.vh"
module onewire_bridge_config_status #(
	parameter ON_TIME_WIDTH = 16
) (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Decoded commands from the host interface engine
	input wire cmd_strobe_i,
	input wire [7:0] cmd_code_i,
	input wire [7:0] cmd_param_i,
	input wire addr_read_ack_i,
	output wire cmd_nack_o,
	// Read path
	input wire [7:0] read_data_i,
	output reg [7:0] rd_data_o,
	// Bus sequencer events
	input wire bus_cmd_start_i,
	input wire bus_cmd_done_i,
	input wire slot_sample_i,
	input wire presence_sample_i,
	input wire single_bit_sample_i,
	input wire triplet_second_sample_i,
	input wire direction_valid_i,
	input wire direction_i,
	input wire presence_window_i,
	input wire line_drive_low_i,
	// Bus line and pullup control
	input wire line_i,
	output reg pullup_drive_o,
	output reg ext_pullup_ctrl_n_o,
	// Configuration to the sequencer
	output wire bus_speed_sel_o,
	output wire active_pullup_sel_o,
	output wire strong_pullup_sel_o
);

localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_ACTIVE = 3'b010;
localparam [2:0] ST_STRONG = 3'b100;
localparam [31:0] ON_CYCLES_FULL = `ACTIVE_PULLUP_ON_CYCLES;
localparam [ON_TIME_WIDTH-1:0] ON_CYCLES = ON_CYCLES_FULL[ON_TIME_WIDTH-1:0];
localparam [7:0] CFG_RESET = `CFG_RESET_VALUE;

// Pointer code check shared by refusal and update paths
function valid_pointer;
	input [7:0] code;
	begin
		valid_pointer = (code == `PTR_STATUS) || (code == `PTR_READ_DATA) ||
			(code == `PTR_CONFIG);
	end
endfunction

// Nibble check of a configuration byte
function config_ok;
	input [7:0] value;
	begin
		config_ok = (value[7:4] == ~value[3:0]);
	end
endfunction

wire line_level;
wire line_rise;

line_sampler u_line_sampler (
	.clock_i(clock_i),
	.rst_i(rst_i),
	.line_i(line_i),
	.level_o(line_level),
	.rise_o(line_rise),
	.fall_o()
);

reg [7:0] pointer_reg;
reg [7:0] pointer_next;
reg active_pullup_reg;
reg active_pullup_next;
reg strong_pullup_reg;
reg strong_pullup_next;
reg bus_speed_reg;
reg bus_speed_next;
reg busy_reg;
reg busy_next;
reg presence_reg;
reg presence_next;
reg short_reg;
reg short_next;
reg line_level_reg;
reg line_level_next;
reg reset_flag_reg;
reg reset_flag_next;
reg single_bit_reg;
reg single_bit_next;
reg triplet_reg;
reg triplet_next;
reg direction_reg;
reg direction_next;
reg [2:0] state_reg;
reg [2:0] state_next;
reg [ON_TIME_WIDTH-1:0] on_count_reg;
reg [ON_TIME_WIDTH-1:0] on_count_next;
reg [7:0] rd_data_next;

wire is_dev_reset = cmd_strobe_i && (cmd_code_i == `CMD_DEVICE_RESET);
wire is_set_ptr = cmd_strobe_i && (cmd_code_i == `CMD_SET_POINTER);
wire is_cfg_write = cmd_strobe_i && (cmd_code_i == `CMD_WRITE_CONFIG);
wire cfg_accept = is_cfg_write && config_ok(cmd_param_i);
wire strong_end = (state_reg == ST_STRONG) && (bus_cmd_start_i || is_dev_reset ||
	(cfg_accept && !cmd_param_i[`CFG_STRONG_PULLUP]));
// Presence-pulse end and short recovery are let rise on the resistor alone
wire pullup_blocked = presence_window_i || short_reg || line_drive_low_i;

// Invalid pointer code is refused at its acknowledge
assign cmd_nack_o = is_set_ptr && !valid_pointer(cmd_param_i);

wire [7:0] status_value = {direction_next, triplet_next, single_bit_next, reset_flag_next,
	line_level_next, short_next, presence_next & ~short_next, busy_next};
wire [7:0] config_value = {4'h0, bus_speed_next, strong_pullup_next, 1'b0,
	active_pullup_next};

assign bus_speed_sel_o = bus_speed_reg;
assign active_pullup_sel_o = active_pullup_reg;
assign strong_pullup_sel_o = strong_pullup_reg;

// Pointer and configuration
always @* begin
	pointer_next = pointer_reg;
	active_pullup_next = active_pullup_reg;
	strong_pullup_next = strong_pullup_reg;
	bus_speed_next = bus_speed_reg;
	if (is_dev_reset) begin
		pointer_next = `PTR_STATUS;
		active_pullup_next = 1'b0;
		strong_pullup_next = 1'b0;
		bus_speed_next = 1'b0;
	end else begin
		if (bus_cmd_start_i) begin
			pointer_next = `PTR_STATUS;
		end
		if (is_set_ptr && valid_pointer(cmd_param_i)) begin
			pointer_next = cmd_param_i;
		end
		if (is_cfg_write) begin
			pointer_next = `PTR_CONFIG;
		end
		if (strong_end) begin
			strong_pullup_next = 1'b0;
		end
		if (cfg_accept) begin
			active_pullup_next = cmd_param_i[`CFG_ACTIVE_PULLUP];
			strong_pullup_next = cmd_param_i[`CFG_STRONG_PULLUP];
			bus_speed_next = cmd_param_i[`CFG_BUS_SPEED];
			if (strong_end) begin
				strong_pullup_next = 1'b0;
			end
		end
	end
end

// Status flags
always @* begin
	busy_next = busy_reg;
	presence_next = presence_reg;
	short_next = short_reg;
	line_level_next = line_level_reg;
	reset_flag_next = reset_flag_reg;
	single_bit_next = single_bit_reg;
	triplet_next = triplet_reg;
	direction_next = direction_reg;
	if (is_dev_reset) begin
		reset_flag_next = 1'b1;
		busy_next = 1'b0;
		presence_next = 1'b0;
		short_next = 1'b0;
		single_bit_next = 1'b0;
		triplet_next = 1'b0;
		direction_next = 1'b0;
	end else begin
		// A start in the same cycle as a done belongs to the next command
		if (bus_cmd_done_i) begin
			busy_next = 1'b0;
		end
		if (bus_cmd_start_i) begin
			busy_next = 1'b1;
		end
		if (slot_sample_i) begin
			short_next = ~line_level;
			if (!line_level) begin
				presence_next = 1'b0;
			end
		end
		if (presence_sample_i) begin
			presence_next = ~line_level & ~short_next;
		end
		if (addr_read_ack_i && pointer_reg == `PTR_STATUS) begin
			line_level_next = line_level;
		end
		if (is_cfg_write) begin
			reset_flag_next = 1'b0;
		end
		if (single_bit_sample_i) begin
			single_bit_next = line_level;
		end
		if (triplet_second_sample_i) begin
			triplet_next = line_level;
		end
		if (direction_valid_i) begin
			direction_next = direction_i;
		end
	end
end

// Pullup control
always @* begin
	state_next = state_reg;
	on_count_next = on_count_reg;
	case (state_reg)
		ST_IDLE: begin
			if (line_rise && !pullup_blocked) begin
				if (strong_pullup_reg) begin
					state_next = ST_STRONG;
				end else if (active_pullup_reg) begin
					state_next = ST_ACTIVE;
					on_count_next = ON_CYCLES;
				end
			end
		end
		ST_ACTIVE: begin
			if (on_count_reg <= 1 || line_drive_low_i || is_dev_reset) begin
				state_next = ST_IDLE;
				on_count_next = {ON_TIME_WIDTH{1'b0}};
			end else begin
				on_count_next = on_count_reg - 1'b1;
			end
		end
		ST_STRONG: begin
			if (strong_end) begin
				state_next = ST_IDLE;
			end
		end
		default: begin
			state_next = ST_IDLE;
			on_count_next = {ON_TIME_WIDTH{1'b0}};
		end
	endcase
end

// Built from next state, so a read right after a command is never stale
always @* begin
	case (pointer_next)
		`PTR_CONFIG: rd_data_next = config_value;
		`PTR_READ_DATA: rd_data_next = read_data_i;
		default: rd_data_next = status_value;
	endcase
end

always @(posedge clock_i) begin
	if (rst_i) begin
		pointer_reg <= `PTR_STATUS;
		active_pullup_reg <= CFG_RESET[`CFG_ACTIVE_PULLUP];
		strong_pullup_reg <= CFG_RESET[`CFG_STRONG_PULLUP];
		bus_speed_reg <= CFG_RESET[`CFG_BUS_SPEED];
		busy_reg <= 1'b0;
		presence_reg <= 1'b0;
		short_reg <= 1'b0;
		line_level_reg <= 1'b0;
		reset_flag_reg <= 1'b1;
		single_bit_reg <= 1'b0;
		triplet_reg <= 1'b0;
		direction_reg <= 1'b0;
		state_reg <= ST_IDLE;
		on_count_reg <= {ON_TIME_WIDTH{1'b0}};
		rd_data_o <= 8'h00;
		pullup_drive_o <= 1'b0;
		ext_pullup_ctrl_n_o <= 1'b1;
	end else begin
		pointer_reg <= pointer_next;
		active_pullup_reg <= active_pullup_next;
		strong_pullup_reg <= strong_pullup_next;
		bus_speed_reg <= bus_speed_next;
		busy_reg <= busy_next;
		presence_reg <= presence_next;
		short_reg <= short_next;
		line_level_reg <= line_level_next;
		reset_flag_reg <= reset_flag_next;
		single_bit_reg <= single_bit_next;
		triplet_reg <= triplet_next;
		direction_reg <= direction_next;
		state_reg <= state_next;
		on_count_reg <= on_count_next;
		rd_data_o <= rd_data_next;
		pullup_drive_o <= (state_next != ST_IDLE);
		ext_pullup_ctrl_n_o <= (state_next != ST_STRONG);
	end
end

endmodule

//--- tb/onewire_bridge_props.sv
// Checker for the bridge configuration and status block
`timescale 1ns/1ps
`include "onewire_bridge_map.vh"
module onewire_bridge_props (
	// Clock and reset
	input wire clock_i,
	input wire rst_i,
	// Commands and read path
	input wire cmd_strobe_i,
	input wire [7:0] cmd_code_i,
	input wire [7:0] cmd_param_i,
	input wire cmd_nack_o,
	input wire [7:0] rd_data_o,
	input wire bus_cmd_start_i,
	// Pullup and configuration
	input wire pullup_drive_o,
	input wire ext_pullup_ctrl_n_o,
	input wire bus_speed_sel_o,
	input wire active_pullup_sel_o,
	input wire strong_pullup_sel_o
);
	wire wr = cmd_strobe_i && cmd_code_i == `CMD_WRITE_CONFIG;
	wire dr = cmd_strobe_i && cmd_code_i == `CMD_DEVICE_RESET;
	wire ok = cmd_param_i[7:4] == ~cmd_param_i[3:0];
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	property p_nack;
		cmd_nack_o == (cmd_strobe_i && cmd_code_i == `CMD_SET_POINTER && cmd_param_i != `PTR_STATUS
			&& cmd_param_i != `PTR_READ_DATA && cmd_param_i != `PTR_CONFIG);
	endproperty
	a_nack: assert property (p_nack) else $error("nack wrong");
	property p_bad_wr;
		wr && !ok |=> $stable({active_pullup_sel_o, bus_speed_sel_o});
	endproperty
	a_bad_wr: assert property (p_bad_wr) else $error("bad write taken");
	property p_good_wr;
		wr && ok |=> rd_data_o == ($past(cmd_param_i) & 8'h0d)
			&& {bus_speed_sel_o, active_pullup_sel_o} == {rd_data_o[3], rd_data_o[0]};
	endproperty
	a_good_wr: assert property (p_good_wr) else $error("config readback wrong");
	property p_keep;
		$changed({active_pullup_sel_o, bus_speed_sel_o}) |-> $past(wr) || $past(dr);
	endproperty
	a_keep: assert property (p_keep) else $error("config bit moved");
	property p_spu_end;
		!ext_pullup_ctrl_n_o && bus_cmd_start_i |=> ext_pullup_ctrl_n_o && !strong_pullup_sel_o;
	endproperty
	a_spu_end: assert property (p_spu_end) else $error("strong pullup kept");
	property p_ext;
		!ext_pullup_ctrl_n_o |-> pullup_drive_o && strong_pullup_sel_o;
	endproperty
	a_ext: assert property (p_ext) else $error("ext control low wrongly");
	property p_dev_rst;
		dr |=> rd_data_o[7:4] == 4'h1 && rd_data_o[2:0] == 3'h0 && ext_pullup_ctrl_n_o
			&& !(active_pullup_sel_o || bus_speed_sel_o || strong_pullup_sel_o);
	endproperty
	a_dev_rst: assert property (p_dev_rst) else $error("device reset wrong");
	property p_busy;
		bus_cmd_start_i && !cmd_strobe_i |=> rd_data_o[0];
	endproperty
	a_busy: assert property (p_busy) else $error("busy not shown");
	c_bad_wr: cover property (wr && !ok);
	c_spu_end: cover property (!ext_pullup_ctrl_n_o && bus_cmd_start_i);
	c_nack: cover property (cmd_nack_o);
endmodule
bind onewire_bridge_config_status onewire_bridge_props u_onewire_bridge_props (
	.clock_i(clock_i),
	.rst_i(rst_i),
	.cmd_strobe_i(cmd_strobe_i),
	.cmd_code_i(cmd_code_i),
	.cmd_param_i(cmd_param_i),
	.cmd_nack_o(cmd_nack_o),
	.rd_data_o(rd_data_o),
	.bus_cmd_start_i(bus_cmd_start_i),
	.pullup_drive_o(pullup_drive_o),
	.ext_pullup_ctrl_n_o(ext_pullup_ctrl_n_o),
	.bus_speed_sel_o(bus_speed_sel_o),
	.active_pullup_sel_o(active_pullup_sel_o),
	.strong_pullup_sel_o(strong_pullup_sel_o)
);

//--- tb/bus_line_model.sv
// Single-wire line with its pull-up resistor and one slave
`timescale 1ns/1ps
module bus_line_model (
	// Pull-down sources
	input wire line_drive_low_i,
	input wire slave_low_i,
	// Wired-and level
	output reg line_o
);
	// Released line floats high; slave acts on its own grid, not the clock's
	initial line_o = 1'b1;
	always #80 line_o = !(line_drive_low_i || slave_low_i);
endmodule

//--- tb/onewire_bridge_config_status_test.sv
// Self-checking bench for the bridge configuration and status block
`timescale 1ns/1ps
`include "onewire_bridge_map.vh"
module onewire_bridge_config_status_test;
	reg clock_i = 1'b0, rst_i = 1'b1, cmd_strobe_i = 1'b0, addr_read_ack_i = 1'b0;
	reg bus_cmd_start_i = 1'b0, bus_cmd_done_i = 1'b0, slot_sample_i = 1'b0;
	reg presence_sample_i = 1'b0, single_bit_sample_i = 1'b0, triplet_second_sample_i = 1'b0;
	reg direction_valid_i = 1'b0, direction_i = 1'b0, presence_window_i = 1'b0;
	reg line_drive_low_i = 1'b0, slave_low = 1'b0, chk = 1'b0, chk_d = 1'b0;
	reg [7:0] cmd_code_i = 8'h00, cmd_param_i = 8'h00, read_data_i = 8'h00, evt = 8'h00;
	reg [7:0] s = 8'h10, cfg = 8'h00;
	reg [31:0] r;
	reg [7:0] exp_q[$];
	integer errors = 0, n_compared = 0, cyc = 0, i;
	wire line_i, cmd_nack_o, pullup_drive_o, ext_pullup_ctrl_n_o, bus_speed_sel_o;
	wire active_pullup_sel_o, strong_pullup_sel_o;
	wire [7:0] rd_data_o;
	onewire_bridge_config_status u_onewire_bridge_config_status (.*);
	bus_line_model u_bus_line_model (.line_drive_low_i(line_drive_low_i),
		.slave_low_i(slave_low), .line_o(line_i));
	always @* begin
		{direction_valid_i, triplet_second_sample_i, single_bit_sample_i, presence_sample_i,
			slot_sample_i, bus_cmd_done_i, bus_cmd_start_i, addr_read_ack_i} = evt;
	end
	initial begin
		forever #5 clock_i = ~clock_i;
	end
	function [7:0] sv();
		sv = s & ~{6'h0, s[2], 1'b0};
	endfunction
	task check(input [7:0] seen, input [7:0] want);
		begin
			n_compared = n_compared + 1;
			if (seen !== want) begin
				errors = errors + 1;
				$display("[ERR] %0t seen %h want %h", $time, seen, want);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("Compared %0d, mismatches %0d", n_compared, errors);
			if (errors == 0 && n_compared > 0) begin
				$display("Result: passed");
			end else begin
				$display("Result: failed");
			end
			$finish;
		end
	endtask
	// One request, its expectation noted; an idle edge keeps strobes apart
	task op(input stb, input [7:0] c, input [7:0] p, input [7:0] ev, input nk, input [7:0] e);
		begin
			cmd_strobe_i <= stb;
			cmd_code_i <= c;
			cmd_param_i <= p;
			evt <= ev;
			chk <= 1'b1;
			exp_q.push_back(e);
			#1;
			check({7'h0, cmd_nack_o}, {7'h0, nk});
			@(posedge clock_i);
			cmd_strobe_i <= 1'b0;
			evt <= 8'h00;
			chk <= 1'b0;
			@(posedge clock_i);
		end
	endtask
	// Long enough for the line model tick plus the input synchroniser
	task w;
		repeat (20) @(posedge clock_i);
	endtask
	always @(posedge clock_i) begin
		cyc = cyc + 1;
		if (chk_d) begin
			check(rd_data_o, exp_q.pop_front());
		end
		chk_d <= chk;
		if (cyc == 4000) begin
			errors = errors + 1;
			tally_and_finish;
		end
	end
	initial begin
		r = $urandom(32'hd64cbfa5);
		repeat (3) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		op(0, 0, 0, 0, 0, sv());
		for (i = 0; i < 4; i = i + 1) begin
			r = $urandom;
			// Last write leaves active pullup on for the rising-edge check
			cfg = {4'h0, (r[3:0] & 4'h9) | {3'h0, i == 3}};
			s[`STS_RESET] = 1'b0;
			op(1, `CMD_WRITE_CONFIG, {~cfg[3:0], cfg[3:0]}, 0, 0, cfg);
		end
		op(1, `CMD_WRITE_CONFIG, {cfg[3:0], cfg[3:0]}, 0, 0, cfg);
		read_data_i <= r[15:8];
		op(1, `CMD_SET_POINTER, `PTR_STATUS, 0, 0, sv());
		op(1, `CMD_SET_POINTER, `PTR_READ_DATA, 0, 0, read_data_i);
		op(1, `CMD_SET_POINTER, `PTR_CONFIG, 0, 0, cfg);
		op(1, `CMD_SET_POINTER, 8'h3c, 0, 1, cfg);
		op(1, `CMD_SET_POINTER, `PTR_STATUS, 0, 0, sv());
		for (i = 0; i < 2; i = i + 1) begin
			slave_low <= (i == 0);
			w;
			s[`STS_LINE_LEVEL] = (i != 0);
			op(0, 0, 0, 8'h01, 0, sv());
		end
		s[`STS_BUSY] = 1'b1;
		op(0, 0, 0, 8'h02, 0, sv());
		presence_window_i <= 1'b1;
		slave_low <= 1'b1;
		w;
		s[`STS_PRESENCE] = 1'b1;
		op(0, 0, 0, 8'h10, 0, sv());
		slave_low <= 1'b0;
		w;
		presence_window_i <= 1'b0;
		s[`STS_BUSY] = 1'b0;
		op(0, 0, 0, 8'h04, 0, sv());
		slave_low <= 1'b1;
		w;
		s[`STS_BUSY] = 1'b1;
		s[`STS_SHORT] = 1'b1;
		op(0, 0, 0, 8'h0a, 0, sv());
		slave_low <= 1'b0;
		w;
		s[`STS_SHORT] = 1'b0;
		s[`STS_PRESENCE] = 1'b0;
		op(0, 0, 0, 8'h18, 0, sv());
		slave_low <= 1'b1;
		w;
		s[`STS_SINGLE_BIT] = 1'b0;
		op(0, 0, 0, 8'h20, 0, sv());
		slave_low <= 1'b0;
		direction_i <= 1'b1;
		w;
		check({7'h0, pullup_drive_o}, 8'h01);
		s[7:5] = 3'h7;
		s[`STS_BUSY] = 1'b0;
		op(0, 0, 0, 8'he4, 0, sv());
		cfg = 8'h08;
		op(1, `CMD_WRITE_CONFIG, 8'h78, 0, 0, cfg);
		check({7'h0, bus_speed_sel_o}, 8'h01);
		cfg = 8'h05;
		op(1, `CMD_WRITE_CONFIG, 8'ha5, 0, 0, cfg);
		line_drive_low_i <= 1'b1;
		w;
		line_drive_low_i <= 1'b0;
		w;
		check({6'h0, ext_pullup_ctrl_n_o, pullup_drive_o}, 8'h01);
		s[`STS_BUSY] = 1'b1;
		op(0, 0, 0, 8'h02, 0, sv());
		check({5'h0, ext_pullup_ctrl_n_o, strong_pullup_sel_o, active_pullup_sel_o}, 8'h05);
		check({7'h0, bus_speed_sel_o}, 8'h00);
		s = {4'h1, s[3], 3'h0};
		op(1, `CMD_DEVICE_RESET, 0, 0, 0, s);
		op(1, `CMD_SET_POINTER, `PTR_CONFIG, 0, 0, 8'h00);
		tally_and_finish;
	end
endmodule
